// *** rtl/cc_timer.sv ***
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
module cc_timer import cc_timer_pkg::*; (
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire logic [7:0]      awaddr,
	input  wire logic            awvalid,
	output logic                 awready,
	input  wire logic [31:0]     wdata,
	input  wire logic [3:0]      wstrb,
	input  wire logic            wvalid,
	output logic                 wready,
	output logic [1:0]           bresp,
	output logic                 bvalid,
	input  wire logic            bready,
	input  wire logic [7:0]      araddr,
	input  wire logic            arvalid,
	output logic                 arready,
	output logic [31:0]          rdata,
	output logic [1:0]           rresp,
	output logic                 rvalid,
	input  wire logic            rready,
	input  wire logic [NCH-1:0]  captureInA,
	input  wire logic [NCH-1:0]  captureInB,
	input  wire logic            outputHizPin,
	output logic [NCH-1:0]       channelOutput,
	output logic [NCH-1:0]       outEnableN
);
	// ****************************************
	// Bus slave
	// ****************************************
	logic [7:0] awAddr_ff;
	logic [31:0] wData_ff;
	logic [3:0] wStrb_ff;
	logic awHeld_ff, wHeld_ff, awReady_ff, wReady_ff, bValid_ff, arReady_ff, rValid_ff;
	logic [1:0] bResp_ff, rResp_ff;
	logic [31:0] rData_ff, curWord, wd, strbMask;
	logic doWrite, mapW, mapR;
	logic [31:0] rdWord;

	// Address and data are taken in either order; the write runs once both are held.
	assign doWrite = awHeld_ff && wHeld_ff && !bValid_ff;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awHeld_ff <= 1'b0;
			wHeld_ff <= 1'b0;
			awReady_ff <= 1'b1;
			wReady_ff <= 1'b1;
			bValid_ff <= 1'b0;
			bResp_ff <= RESP_OKAY;
			awAddr_ff <= 8'h00;
			wData_ff <= 32'h00000000;
			wStrb_ff <= 4'h0;
		end else begin
			if (awvalid && awReady_ff) begin
				awHeld_ff <= 1'b1;
				awAddr_ff <= awaddr;
				awReady_ff <= 1'b0;
			end
			if (wvalid && wReady_ff) begin
				wHeld_ff <= 1'b1;
				wData_ff <= wdata;
				wStrb_ff <= wstrb;
				wReady_ff <= 1'b0;
			end
			if (doWrite) begin
				awHeld_ff <= 1'b0;
				wHeld_ff <= 1'b0;
				bValid_ff <= 1'b1;
				bResp_ff <= mapW ? RESP_OKAY : RESP_SLVERR;
			end
			if (bValid_ff && bready) begin
				bValid_ff <= 1'b0;
				awReady_ff <= 1'b1;
				wReady_ff <= 1'b1;
			end
		end
	end

	// Reads answer one cycle after the address is taken.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			arReady_ff <= 1'b1;
			rValid_ff <= 1'b0;
			rData_ff <= 32'h00000000;
			rResp_ff <= RESP_OKAY;
		end else if (arvalid && arReady_ff) begin
			arReady_ff <= 1'b0;
			rValid_ff <= 1'b1;
			rData_ff <= rdWord;
			rResp_ff <= mapR ? RESP_OKAY : RESP_SLVERR;
		end else if (rValid_ff && rready) begin
			rValid_ff <= 1'b0;
			arReady_ff <= 1'b1;
		end
	end
	assign awready = awReady_ff;
	assign wready = wReady_ff;
	assign bvalid = bValid_ff;
	assign bresp = bResp_ff;
	assign arready = arReady_ff;
	assign rvalid = rValid_ff;
	assign rdata = rData_ff;
	assign rresp = rResp_ff;

	// ****************************************
	// Counter
	// ****************************************
	logic [1:0] mode_ff, len_ff, div_ff, grp_ff;
	logic hizSel_ff, ovf_ff, down_ff;
	logic [CW-1:0] cnt_ff, nxt_cnt, maxCnt, per;
	logic [2:0] divCnt_ff, divLim;
	logic nxt_down, wrapEv, tick, counted, zeroEv, perEv, clrWr, cntWr, ctrlWr, perZero;
	logic [CW-1:0] latch [NCH];
	logic [CW-1:0] bufReg [NCH];
	logic [NCH-1:0] eqEv, flag, cov, lvl;
	logic [K_W-1:0] kReg [NCH];
	countMode_t mode;

	assign ctrlWr = doWrite && awAddr_ff == ADDR_CTRL;
	assign cntWr = doWrite && awAddr_ff == ADDR_COUNT;
	assign clrWr = ctrlWr && wd[C_CLR];
	assign mode = countMode_t'(mode_ff);
	assign per = latch[0];
	assign perZero = per == '0 && (mode == MODE_UP || mode == MODE_UPDN);

	// Control word; the clear bit is a one-shot and reads back as zero.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_ff <= 2'h0;
			len_ff <= 2'h0;
			div_ff <= 2'h0;
			grp_ff <= 2'h0;
			hizSel_ff <= 1'b0;
			ovf_ff <= 1'b0;
		end else begin
			if (ctrlWr) begin
				mode_ff <= wd[C_MODE +: 2];
				len_ff <= wd[C_LEN +: 2];
				div_ff <= wd[C_DIV +: 2];
				grp_ff <= wd[C_GRP +: 2];
				hizSel_ff <= wd[C_HIZ];
				ovf_ff <= wd[C_OVF];
			end
			if (wrapEv && counted) begin
				ovf_ff <= 1'b1; // Set wins over a software clear.
			end
		end
	end

	// Length and prescale decode.
	always_comb begin
		case (len_ff)
			2'h0: maxCnt = MAX16;
			2'h1: maxCnt = MAX12;
			2'h2: maxCnt = MAX10;
			default: maxCnt = MAX8;
		endcase
		case (div_ff)
			2'h0: divLim = 3'h0;
			2'h1: divLim = 3'h1;
			2'h2: divLim = 3'h3;
			default: divLim = 3'h7;
		endcase
	end
	assign tick = divCnt_ff >= divLim;
	// A direct write or a clear replaces the step, so it raises no events.
	assign counted = tick && mode != MODE_STOP && !perZero && !cntWr && !clrWr;

	// Prescaler; the clear restarts it so the first tick after clear is a full period.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			divCnt_ff <= 3'h0;
		end else if (clrWr || tick) begin
			divCnt_ff <= 3'h0;
		end else begin
			divCnt_ff <= divCnt_ff + 3'h1;
		end
	end

	// Next count; direction changes only here and on a clear, so a stop keeps it.
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_down = down_ff;
		wrapEv = 1'b0;
		case (mode)
			MODE_UP: begin
				if (cnt_ff >= per) begin
					nxt_cnt = '0;
					wrapEv = 1'b1;
				end else begin
					nxt_cnt = cnt_ff + ONE;
				end
			end
			MODE_CONT: begin
				if (cnt_ff >= maxCnt) begin
					nxt_cnt = '0;
					wrapEv = 1'b1;
				end else begin
					nxt_cnt = cnt_ff + ONE;
				end
			end
			MODE_UPDN: begin
				if (per > maxCnt) begin
					// Oversize period: plain wrap at the length limit.
					nxt_down = 1'b0;
					wrapEv = cnt_ff >= maxCnt;
					nxt_cnt = wrapEv ? '0 : cnt_ff + ONE;
				end else if (!down_ff) begin
					// Reverse at the period; a new smaller period reverses here too.
					if (cnt_ff >= per) begin
						nxt_down = 1'b1;
						nxt_cnt = cnt_ff - ONE;
					end else begin
						nxt_cnt = cnt_ff + ONE;
					end
				end else if (cnt_ff == '0) begin
					// A new period only matters once the descent ends here.
					nxt_down = 1'b0;
					nxt_cnt = ONE;
				end else begin
					wrapEv = cnt_ff == ONE;
					nxt_cnt = cnt_ff - ONE;
				end
			end
			default: begin
				nxt_cnt = cnt_ff;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= '0;
			down_ff <= 1'b0;
		end else if (clrWr) begin
			cnt_ff <= '0;
			down_ff <= 1'b0;
		end else if (cntWr) begin
			cnt_ff <= wd[CW-1:0] & maxCnt;
		end else if (counted) begin
			cnt_ff <= nxt_cnt;
			down_ff <= nxt_down;
		end
	end
	assign zeroEv = counted && nxt_cnt == '0 && cnt_ff != '0;
	assign perEv = counted && nxt_cnt == per;

	// ****************************************
	// Channels
	// ****************************************
	logic [NCH-1:0] written, memb, grpd, allW, eqSig, capNow, doLoad;
	logic [1:0] effLd [NCH];
	logic [2:0] ctlIdx [NCH];
	logic [1:0] hizSync_ff;
	logic [NCH-1:0] oeN_ff;

	// Controlling channel of channel c for the grouping setting g.
	function automatic logic [2:0] ctlOf(input logic [1:0] g, input int c);
		logic [2:0] cc;
		cc = 3'(c);
		case (g)
			2'h1: ctlOf = (c == 0) ? 3'h0 : (cc[0] ? cc : cc - 3'h1);
			2'h2: ctlOf = (c == 0) ? 3'h0 : (c <= 3 ? 3'h1 : 3'h4);
			2'h3: ctlOf = 3'h1;
			default: ctlOf = cc;
		endcase
	endfunction

	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_ch
			logic a1_ff, a2_ff, b1_ff, b2_ff, selLvl_ff, pend_ff, unread_ff, out_ff;
			logic sel, edgeHit, ldEv, bufWr, kWr;
			assign bufWr = doWrite && awAddr_ff == ADDR_CH_BASE + 8'(gi * 8 + 4);
			assign kWr = doWrite && awAddr_ff == ADDR_CH_BASE + 8'(gi * 8);
			assign ctlIdx[gi] = ctlOf(grp_ff, gi);
			assign memb[gi] = grp_ff != 2'h0 && (gi != 0 || grp_ff == 2'h3);
			// A zero load field at the controller drops back to immediate, ungrouped.
			assign grpd[gi] = memb[gi] && kReg[ctlIdx[gi]][K_LD +: 2] != 2'h0;
			assign effLd[gi] = memb[gi] ? kReg[ctlIdx[gi]][K_LD +: 2] : kReg[gi][K_LD +: 2];
			assign eqEv[gi] = counted && nxt_cnt == latch[gi];
			assign eqSig[gi] = eqEv[gi] && !kReg[gi][K_CAP];

			// Every member of the group must have been written since the last load.
			always_comb begin
				allW[gi] = 1'b1;
				for (int j = 0; j < NCH; j++) begin
					if (memb[j] && ctlOf(grp_ff, j) == ctlIdx[gi] && !written[j]) begin
						allW[gi] = 1'b0;
					end
				end
			end

			// Load event selection.
			always_comb begin
				case (effLd[gi])
					2'h0: ldEv = 1'b1;
					2'h1: ldEv = zeroEv;
					2'h2: ldEv = zeroEv || (mode == MODE_UPDN && perEv);
					default: ldEv = grpd[gi] ? eqEv[ctlIdx[gi]] : eqEv[gi];
				endcase
			end
			assign doLoad[gi] = (grpd[gi] ? allW[gi] : written[gi]) && ldEv;

			// The latch has no bus path; it only takes the buffer on a load.
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					latch[gi] <= '0;
					written[gi] <= 1'b0;
				end else begin
					if (doLoad[gi]) begin
						latch[gi] <= bufReg[gi];
						written[gi] <= 1'b0;
					end
					if (bufWr) begin
						written[gi] <= 1'b1;
					end
				end
			end

			// Pins pass two flops; selects 10 and 11 are fixed low and high levels.
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					a1_ff <= 1'b0;
					a2_ff <= 1'b0;
					b1_ff <= 1'b0;
					b2_ff <= 1'b0;
					selLvl_ff <= 1'b0;
				end else begin
					a1_ff <= captureInA[gi];
					a2_ff <= a1_ff;
					b1_ff <= captureInB[gi];
					b2_ff <= b1_ff;
					selLvl_ff <= sel;
				end
			end
			always_comb begin
				case (kReg[gi][K_SEL +: 2])
					2'h0: sel = a2_ff;
					2'h1: sel = b2_ff;
					2'h2: sel = 1'b0;
					default: sel = 1'b1;
				endcase
			end
			assign lvl[gi] = sel;
			assign edgeHit = kReg[gi][K_CAP] && ((kReg[gi][K_EDGE] && sel && !selLvl_ff)
				|| (kReg[gi][K_EDGE + 1] && !sel && selLvl_ff));
			// With sync set the capture waits for the next timer tick.
			assign capNow[gi] = kReg[gi][K_SCS] ? ((edgeHit || pend_ff) && tick) : edgeHit;
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					pend_ff <= 1'b0;
				end else begin
					pend_ff <= kReg[gi][K_SCS] && (edgeHit || pend_ff) && !tick;
				end
			end

			// Buffer: capture overrides a software write in the same cycle.
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					bufReg[gi] <= '0;
				end else if (capNow[gi]) begin
					bufReg[gi] <= cnt_ff;
				end else if (bufWr) begin
					bufReg[gi] <= wd[CW-1:0];
				end
			end

			// Flag and overrun; hardware sets win over software writes.
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					kReg[gi] <= '0;
					flag[gi] <= 1'b0;
					cov[gi] <= 1'b0;
					unread_ff <= 1'b0;
				end else begin
					if (kWr) begin
						kReg[gi] <= wd[K_W-1:0];
						flag[gi] <= wd[K_FLAG];
						cov[gi] <= cov[gi] && wd[K_COV];
					end
					if (arvalid && arReady_ff && araddr == ADDR_CH_BASE + 8'(gi * 8 + 4)) begin
						unread_ff <= 1'b0;
					end
					if (capNow[gi]) begin
						unread_ff <= 1'b1;
						cov[gi] <= cov[gi] || unread_ff;
					end
					if (capNow[gi] || eqSig[gi]) begin
						flag[gi] <= 1'b1;
					end
				end
			end

			// Output unit; mode 0 copies the bit, others act on the clock.
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					out_ff <= 1'b0;
				end else begin
					case (kReg[gi][K_OM +: 3])
						3'h0: out_ff <= kReg[gi][K_OB];
						3'h1: out_ff <= out_ff || eqSig[gi];
						3'h2: out_ff <= eqSig[0] ? 1'b0 : out_ff ^ eqSig[gi];
						3'h3: out_ff <= eqSig[0] ? 1'b0 : out_ff || eqSig[gi];
						3'h4: out_ff <= out_ff ^ eqSig[gi];
						3'h5: out_ff <= out_ff && !eqSig[gi];
						3'h6: out_ff <= eqSig[0] ? 1'b1 : out_ff ^ eqSig[gi];
						default: out_ff <= eqSig[0] ? 1'b1 : out_ff && !eqSig[gi];
					endcase
				end
			end
			assign channelOutput[gi] = out_ff;

			capture_copy_a: assert property (@(posedge clk) disable iff (rst)
				capNow[gi] |=> bufReg[gi] == $past(cnt_ff) && flag[gi] && unread_ff)
				else $error("capture did not copy count");
			overrun_set_a: assert property (@(posedge clk) disable iff (rst)
				capNow[gi] && unread_ff |=> cov[gi])
				else $error("overrun not flagged");
			compare_flag_a: assert property (@(posedge clk) disable iff (rst)
				eqSig[gi] |=> flag[gi])
				else $error("compare flag missing");
			load_now_a: assert property (@(posedge clk) disable iff (rst)
				written[gi] && effLd[gi] == 2'h0 && !grpd[gi] |=> latch[gi] == $past(bufReg[gi]))
				else $error("immediate load missed");
			group_wait_a: assert property (@(posedge clk) disable iff (rst)
				grpd[gi] && !allW[gi] |=> $stable(latch[gi]))
				else $error("group loaded early");
			sync_wait_a: assert property (@(posedge clk) disable iff (rst)
				kReg[gi][K_SCS] && capNow[gi] |-> tick)
				else $error("sync capture off tick");
		end
	endgenerate

	// Hold-off pin: synchronised, then floats every output together.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hizSync_ff <= 2'h0;
			oeN_ff <= '0;
		end else begin
			hizSync_ff <= {hizSync_ff[0], outputHizPin};
			oeN_ff <= {NCH{hizSel_ff && hizSync_ff[1]}};
		end
	end
	assign outEnableN = oeN_ff;

	// ****************************************
	// Register read mux and strobe merge
	// ****************************************
	function automatic logic [31:0] readAt(input logic [7:0] a);
		logic [2:0] c;
		c = 3'((a - ADDR_CH_BASE) >> CH_SHIFT);
		readAt = 32'h00000000;
		if (a == ADDR_CTRL) begin
			readAt[C_MODE +: 2] = mode_ff;
			readAt[C_LEN +: 2] = len_ff;
			readAt[C_DIV +: 2] = div_ff;
			readAt[C_GRP +: 2] = grp_ff;
			readAt[C_HIZ] = hizSel_ff;
			readAt[C_OVF] = ovf_ff;
		end else if (a == ADDR_COUNT) begin
			readAt[CW-1:0] = cnt_ff;
		end else if (a >= ADDR_CH_BASE && a < ADDR_CH_END) begin
			if (a[CH_BUF_BIT]) begin
				readAt[CW-1:0] = bufReg[c];
			end else begin
				readAt[K_W-1:0] = kReg[c];
				readAt[K_FLAG] = flag[c];
				readAt[K_COV] = cov[c];
				readAt[K_LVL] = lvl[c];
			end
		end
	endfunction
	assign mapW = awAddr_ff[1:0] == 2'h0 && awAddr_ff < ADDR_CH_END;
	assign mapR = araddr[1:0] == 2'h0 && araddr < ADDR_CH_END;
	assign rdWord = mapR ? readAt(araddr) : 32'h00000000;
	assign curWord = readAt(awAddr_ff);
	assign strbMask = {{8{wStrb_ff[3]}}, {8{wStrb_ff[2]}}, {8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}};
	assign wd = (curWord & ~strbMask) | (wData_ff & strbMask);

	// ****************************************
	// Checks
	// ****************************************
	clear_all_a: assert property (@(posedge clk) disable iff (rst)
		clrWr |=> cnt_ff == '0 && !down_ff && divCnt_ff == 3'h0)
		else $error("clear left state");
	write_quiet_a: assert property (@(posedge clk) disable iff (rst)
		cntWr && !ovf_ff |=> !ovf_ff)
		else $error("count write raised overflow");
	updn_ovf_a: assert property (@(posedge clk) disable iff (rst)
		mode == MODE_UPDN && per <= maxCnt && counted && down_ff && cnt_ff == ONE |=> ovf_ff && cnt_ff == '0)
		else $error("down overflow missed");
	big_period_a: assert property (@(posedge clk) disable iff (rst)
		mode == MODE_UPDN && per > maxCnt && counted && cnt_ff == maxCnt |=> cnt_ff == '0)
		else $error("oversize period not continuous");
	hiz_out_a: assert property (@(posedge clk) disable iff (rst)
		hizSel_ff && hizSync_ff[1] |=> &outEnableN)
		else $error("outputs not floated");
	peak_turn_a: assert property (@(posedge clk) disable iff (rst)
		mode == MODE_UPDN && per <= maxCnt && counted && !down_ff && cnt_ff == per && per != '0
		|=> down_ff && cnt_ff == $past(per) - ONE)
		else $error("no reversal at period");
	updn_cycle_c: cover property (@(posedge clk) disable iff (rst) mode == MODE_UPDN && wrapEv && counted);
	group_load_c: cover property (@(posedge clk) disable iff (rst) grpd[2] && doLoad[2]);
	capture_ovr_c: cover property (@(posedge clk) disable iff (rst) capNow[1] && cov[1]);
endmodule

// *** shared/cc_timer_pkg.sv ***
// Notes on behaviour
// - Up/down with oversize period acts continuous.
// - Direction held over stop; clear resets all.
// - Up/down flags at period and at 1-to-0.
// - Period change while descending waits for zero.
// - Larger new period is counted up to.
// - Smaller new period reverses, maybe one late.
// - Seven identical capture/compare channels.
// - Capture select, input select, edge select.
// - Capture copies count and sets flag.
// - Selected input level readable any time.
// - Sync bit delays capture to timer tick.
// - Second unread capture sets overrun bit.
// - Upper select bit gives software capture levels.
// - Compare match sets flag and equal signal.
// - Compare latch reachable only through buffer.
// - Load field 00 immediate, 01 at zero.
// - Load field 10 zero, or period up/down.
// - Load field 11 at old latch value.
// - Grouping field forms pairs, triples or all.
// - Lowest group channel's load field governs; channel 1 when grouping all.
// - Zero controlling load field cancels grouping.
// - Group loads after all members written.
// - Hold-off pin function floats all outputs.
// - Mode 11 counts up then down.
// - Direct counter writes raise no events.
// - Outputs update on clock; mode 0 follows bit.
package cc_timer_pkg;
	localparam int NCH = 7;
	localparam int CW = 16;
	typedef enum logic [1:0] {MODE_STOP, MODE_UP, MODE_CONT, MODE_UPDN} countMode_t;
	// Byte addresses of the register words.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_COUNT = 8'h04;
	localparam logic [7:0] ADDR_CH_BASE = 8'h08;
	localparam logic [7:0] ADDR_CH_END = 8'h40;
	localparam int CH_SHIFT = 3;
	localparam int CH_BUF_BIT = 2;
	// Control word fields.
	localparam int C_MODE = 0;
	localparam int C_LEN = 2;
	localparam int C_DIV = 4;
	localparam int C_GRP = 6;
	localparam int C_HIZ = 8;
	localparam int C_CLR = 9;
	localparam int C_OVF = 10;
	// Channel control word fields.
	localparam int K_FLAG = 0;
	localparam int K_COV = 1;
	localparam int K_LVL = 2;
	localparam int K_CAP = 3;
	localparam int K_SEL = 4;
	localparam int K_EDGE = 6;
	localparam int K_SCS = 8;
	localparam int K_LD = 9;
	localparam int K_OM = 11;
	localparam int K_OB = 14;
	localparam int K_W = 15;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [CW-1:0] MAX16 = 16'hFFFF;
	localparam logic [CW-1:0] MAX12 = 16'h0FFF;
	localparam logic [CW-1:0] MAX10 = 16'h03FF;
	localparam logic [CW-1:0] MAX8 = 16'h00FF;
	localparam logic [CW-1:0] ONE = 16'h0001;
endpackage

// *** bench/tb_top.sv ***
`timescale 1ns/10ps
module tb_top import cc_timer_pkg::*; ();
	// ************************************************************
	// Signals and the block under test
	// ************************************************************
	logic            clk;
	logic            rst;
	logic            awvalid;
	logic            wvalid;
	logic            bready;
	logic            arvalid;
	logic            rready;
	logic            outputHizPin;
	logic            awready;
	logic            wready;
	logic            bvalid;
	logic            arready;
	logic            rvalid;
	logic [7:0]      awaddr;
	logic [7:0]      araddr;
	logic [3:0]      wstrb;
	logic [31:0]     wdata;
	logic [31:0]     rdata;
	logic [31:0]     rd;
	logic [1:0]      bresp;
	logic [1:0]      rresp;
	logic [1:0]      rsp;
	logic [NCH-1:0]  captureInA;
	logic [NCH-1:0]  captureInB;
	logic [NCH-1:0]  channelOutput;
	logic [NCH-1:0]  outEnableN;
	int              n_errors;
	int              comparisons;
	int              cycles;

	cc_timer dut (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .captureInA(captureInA),
		.captureInB(captureInB), .outputHizPin(outputHizPin), .channelOutput(channelOutput),
		.outEnableN(outEnableN));

	// ************************************************************
	// Bus cycles, comparison and closing report
	// ************************************************************
	// Free-running clock at 50 MHz.
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Cuts a hang short; the whole run needs about fourteen hundred cycles.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			print_verdict();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Address and data are offered together; each is dropped once taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit aDone;
		bit wDone;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		aDone = 0;
		wDone = 0;
		while (!(aDone && wDone)) begin
			@(posedge clk);
			if (awvalid && awready) begin
				aDone = 1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				wDone = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (!bvalid);
		rsp = bresp;
	endtask

	task automatic rdr(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rd = rdata;
		rsp = rresp;
	endtask

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic testBus();
		rdr(8'h00);
		chk("control after reset", rd, 32'h0);
		rdr(8'h40);
		chk("unmapped read resp", 32'(rsp), 32'h2);
		wr(8'h44, 32'h1);
		chk("unmapped write resp", 32'(rsp), 32'h2);
		$display("test bus done");
	endtask

	// Period 5 in up/down mode; a continuous counter would run far past it.
	task automatic testUpDown();
		wr(8'h0C, 32'h5);
		wr(8'h00, 32'h3);
		for (int i = 0; i < 8; i++) begin
			rdr(8'h04);
			chk("count bounded", 32'(rd <= 32'h5), 32'h1);
		end
		rdr(8'h00);
		chk("overflow flag", 32'(rd[10]), 32'h1);
		rdr(8'h08);
		chk("period flag", 32'(rd[0]), 32'h1);
		wr(8'h00, 32'h200);
		rdr(8'h04);
		chk("count cleared", rd, 32'h0);
		// Slow ticks keep the period out of reach while the flag is cleared and the count written.
		wr(8'h00, 32'h33);
		wr(8'h08, 32'h0);
		wr(8'h04, 32'h5);
		repeat (5) @(posedge clk);
		rdr(8'h08);
		chk("written count no event", 32'(rd[0]), 32'h0);
		// Oversize period at 8-bit length wraps like continuous: five counts past the wrap.
		wr(8'h0C, 32'h1F0);
		wr(8'h00, 32'h20F);
		repeat (260) @(posedge clk);
		rdr(8'h04);
		chk("oversize period wraps", rd, 32'h5);
		$display("test up/down done");
	endtask

	// Software capture toggles between the fixed levels, then a pin edge.
	task automatic testCapture();
		logic [31:0] c1;
		logic [31:0] v;
		wr(8'h00, 32'h2);
		wr(8'h18, 32'h1F8);
		rdr(8'h18);
		chk("input level high", 32'(rd[2]), 32'h1);
		rdr(8'h1C);
		rdr(8'h04);
		c1 = rd;
		wr(8'h18, 32'h1E8);
		rdr(8'h18);
		chk("flag level overrun", 32'(rd[2:0]), 32'h1);
		rdr(8'h1C);
		v = rd;
		rdr(8'h04);
		chk("captured in range", 32'(v > c1 && v < rd), 32'h1);
		wr(8'h18, 32'h1F8);
		wr(8'h18, 32'h1E8);
		rdr(8'h18);
		chk("overrun set", 32'(rd[1]), 32'h1);
		wr(8'h18, 32'h1E8);
		rdr(8'h18);
		chk("overrun cleared", 32'(rd[1]), 32'h0);
		wr(8'h18, 32'h148);
		captureInA[2] <= 1'b1;
		repeat (8) @(posedge clk);
		rdr(8'h18);
		chk("pin rise capture", 32'(rd[0]), 32'h1);
		$display("test capture done");
	endtask

	// 8-bit continuous count from a clear: wrap every 256 cycles.
	task automatic testCompare();
		wr(8'h00, 32'h20E);
		wr(8'h20, 32'h800);
		wr(8'h24, 32'h40);
		wr(8'h28, 32'h200);
		wr(8'h2C, 32'h40);
		repeat (80) @(posedge clk);
		rdr(8'h20);
		chk("immediate load match", 32'(rd[0]), 32'h1);
		chk("equal sets output", 32'(channelOutput[3]), 32'h1);
		rdr(8'h28);
		chk("zero load waits", 32'(rd[0]), 32'h0);
		repeat (180) @(posedge clk);
		wr(8'h28, 32'h200);
		repeat (60) @(posedge clk);
		rdr(8'h28);
		chk("loaded after wrap", 32'(rd[0]), 32'h1);
		$display("test compare done");
	endtask

	// Pair 1+2 loads at zero only once both buffers are written; the old latches sit at F0.
	task automatic testGroup();
		wr(8'h18, 32'h0);
		wr(8'h14, 32'hF0);
		wr(8'h1C, 32'hF0);
		wr(8'h10, 32'h200);
		wr(8'h00, 32'h24E);
		wr(8'h14, 32'h20);
		repeat (280) @(posedge clk);
		wr(8'h10, 32'h200);
		repeat (20) @(posedge clk);
		rdr(8'h10);
		chk("lone member not loaded", 32'(rd[0]), 32'h0);
		wr(8'h1C, 32'h30);
		repeat (200) @(posedge clk);
		wr(8'h10, 32'h200);
		wr(8'h18, 32'h0);
		repeat (60) @(posedge clk);
		rdr(8'h10);
		chk("pair loaded channel 1", 32'(rd[0]), 32'h1);
		rdr(8'h18);
		chk("pair loaded channel 2", 32'(rd[0]), 32'h1);
		$display("test group done");
	endtask

	task automatic testOutputs();
		wr(8'h30, 32'h4000);
		repeat (2) @(posedge clk);
		chk("mode zero output", 32'(channelOutput[5]), 32'h1);
		wr(8'h00, 32'h100);
		outputHizPin <= 1'b1;
		repeat (5) @(posedge clk);
		chk("outputs floated", 32'(outEnableN), 32'h7F);
		outputHizPin <= 1'b0;
		repeat (5) @(posedge clk);
		chk("outputs driven", 32'(outEnableN), 32'h0);
		wr(8'h00, 32'h0);
		outputHizPin <= 1'b1;
		repeat (5) @(posedge clk);
		chk("function off", 32'(outEnableN), 32'h0);
		$display("test outputs done");
	endtask

	// Every input gets a value at time zero; reset spans sixteen cycles.
	initial begin
		{rst, bready, rready} = 3'h7;
		{awvalid, wvalid, arvalid, outputHizPin} = 4'h0;
		{awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hF};
		{captureInA, captureInB} = 14'h0;
		{n_errors, comparisons, cycles} = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		testBus();
		testUpDown();
		testCapture();
		testCompare();
		testGroup();
		testOutputs();
		print_verdict();
	end
endmodule
